/* File: tsir_defs.vh */
`ifndef TSIR_DEFS_VH
`define TSIR_DEFS_VH
// Register indices, byte address is index times four
`define TSIR_IDX_FREQ 8'h07
`define TSIR_IDX_STAT 8'h08
`define TSIR_IDX_MASK 8'h20
`define TSIR_IDX_CFG 8'h21
`define TSIR_ADDR_FREQ 12'h01C
`define TSIR_ADDR_STAT 12'h020
`define TSIR_ADDR_MASK 12'h080
`define TSIR_ADDR_CFG 12'h084
// Status register layout
`define TSIR_STAT_RESET 8'h50
`define TSIR_STAT_USED 8'hDF
`define TSIR_BIT_SYNC 7
`define TSIR_BIT_LOCK 6
`define TSIR_BIT_NOIN 4
`define TSIR_BIT_IN2V 3
`define TSIR_BIT_IN2L 2
`define TSIR_BIT_IN1V 1
`define TSIR_BIT_IN1L 0
// Frequency readout field
`define TSIR_FREQ_HI 18
`define TSIR_FREQ_LO 16
`define TSIR_FREQ_W 19
// Config register fields
`define TSIR_CFG_SEL 0
`define TSIR_MASK_RESET 8'h00
`define TSIR_CFG_RESET 1'b0
`define TSIR_ADDR_W 12
// Widths of the register byte, bus word and readout field
`define TSIR_REG_W 8
`define TSIR_DATA_W 32
`define TSIR_FIELD_W 3
// Event line positions after synchronisation
`define TSIR_EV_W 7
`define TSIR_EV_SYNC 6
`define TSIR_EV_LOCK 5
`define TSIR_EV_NOIN 4
`define TSIR_EV_IN2V 3
`define TSIR_EV_IN2L 2
`define TSIR_EV_IN1V 1
`define TSIR_EV_IN1L 0
`endif

/* File: tsir_sync2.v */
`timescale 1ns/1ps
`default_nettype none
// Two-flop synchroniser for a bundle of pin levels
module tsir_sync2 #(
  parameter W = 8
) (
  // Clocking
  input wire clock,
  input wire rst_b,
  input wire clockEn,
  // Data
  input wire [W-1:0] asyncIn,
  output reg [W-1:0] syncOut
);
  // First stage, read only by the second stage
  reg [W-1:0] stageOne;

  // Two stages, frozen when the enable is low
  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stageOne <= {W{1'b0}};
      syncOut <= {W{1'b0}};
    end
    else if (clockEn)
    begin
      stageOne <= asyncIn;
      syncOut <= stageOne;
    end
  end
endmodule // tsir_sync2
`default_nettype wire

/* File: tsir_top.v */
`timescale 1ns/1ps
`default_nettype none
`include "tsir_defs.vh"
// Behaviour
// (R1) Readout gives selected loop frequency bits 18:16
// (R2) Status low byte resets 0x50, bit5 unused
// (R3) Bit7 latches frame-sync input alarm
// (R4) Input one: bit1 violation, bit0 loss
// (R5) Input two: bit3 violation, bit2 loss
// (R6) Writing one clears bit, zero keeps
// (R7) Bit6 lock change, bit4 no inputs
module tsir_top (
  // Clock, reset, enable
  input wire clock,
  input wire rst_b,
  input wire clockEn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`TSIR_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Loop frequencies from logic on this clock
  input wire [`TSIR_FREQ_W-1:0] mainLoopFreq,
  input wire [`TSIR_FREQ_W-1:0] auxLoopFreq,
  // Event pins, asynchronous levels
  input wire frameSyncInAlarm,
  input wire auxLoopLocked,
  input wire auxLoopNoInputs,
  input wire inTwoCodeViolation,
  input wire inTwoSignalLoss,
  input wire inOneCodeViolation,
  input wire inOneSignalLoss,
  // Interrupt
  output reg irq
);
  // Synchronised event levels, one per pin
  wire [`TSIR_EV_W-1:0] evSync;
  // Levels seen one cycle earlier
  reg [`TSIR_EV_W-1:0] evPrev;
  // Rising edge of each event line
  wire [`TSIR_EV_W-1:0] evRise;
  // Falling edge of each event line
  wire [`TSIR_EV_W-1:0] evFall;
  // Sticky status byte
  reg [`TSIR_REG_W-1:0] status;
  // Interrupt mask, same layout as status
  reg [`TSIR_REG_W-1:0] mask;
  // Report path select, low picks the main loop
  reg reportPathSelect;
  // Event set vector in status layout
  reg [`TSIR_REG_W-1:0] setVec;
  // Clear vector from software
  reg [`TSIR_REG_W-1:0] clrVec;
  // Frequency field of the selected loop
  reg [`TSIR_FIELD_W-1:0] freqField;
  // Next state of the registers
  wire [`TSIR_REG_W-1:0] next_status;
  reg [`TSIR_REG_W-1:0] next_mask;
  reg next_reportPathSelect;
  // Next state of the bus answer
  reg [`TSIR_DATA_W-1:0] next_prdata;
  reg next_pslverr;
  reg next_pready;
  // Next state of the interrupt line
  reg next_irq;
  // Bus decode
  wire access;
  wire wrAccess;
  wire rdAccess;
  // Address hits, one per register
  wire hitFreq;
  wire hitStat;
  wire hitMask;
  wire hitCfg;
  // Any register hit
  wire mapped;
  // Bits of the status byte that hold a flag
  localparam [`TSIR_REG_W-1:0] STAT_USED = `TSIR_STAT_USED;
  // Loop index for the per-bit logic
  genvar g;

  // Pin levels pass two flops before any logic reads them
  tsir_sync2 #(
    .W(`TSIR_EV_W)
  ) uSync (
    .clock(clock),
    .rst_b(rst_b),
    .clockEn(clockEn),
    .asyncIn({frameSyncInAlarm, auxLoopLocked, auxLoopNoInputs, inTwoCodeViolation,
              inTwoSignalLoss, inOneCodeViolation, inOneSignalLoss}),
    .syncOut(evSync)
  );

  // Keep the previous synchronised levels for edge detection
  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      // Matches the synchroniser reset, so no false edge
      evPrev <= {`TSIR_EV_W{1'b0}};
    end
    else if (clockEn)
    begin
      // Frozen together with the synchroniser
      evPrev <= evSync;
    end
  end

  // Edge detectors, one per event line
  generate
    for (g = 0; g < `TSIR_EV_W; g = g + 1)
    begin : gEdge
      // Level went from low to high
      assign evRise[g] = evSync[g] && !evPrev[g];
      // Level went from high to low
      assign evFall[g] = !evSync[g] && evPrev[g];
    end
  endgenerate

  // Map event edges onto the status layout
  always @*
  begin
    setVec = {`TSIR_REG_W{1'b0}};
    // Frame-sync monitor reached its alarm limit
    setVec[`TSIR_BIT_SYNC] = evRise[`TSIR_EV_SYNC]; // R3
    // Auxiliary loop gained or lost lock
    setVec[`TSIR_BIT_LOCK] = evRise[`TSIR_EV_LOCK] || evFall[`TSIR_EV_LOCK]; // R7
    // Auxiliary loop has no valid input
    setVec[`TSIR_BIT_NOIN] = evRise[`TSIR_EV_NOIN]; // R7
    // Second input, code violation and signal loss
    setVec[`TSIR_BIT_IN2V] = evRise[`TSIR_EV_IN2V]; // R5
    setVec[`TSIR_BIT_IN2L] = evRise[`TSIR_EV_IN2L]; // R5
    // First input, code violation and signal loss
    setVec[`TSIR_BIT_IN1V] = evRise[`TSIR_EV_IN1V]; // R4
    setVec[`TSIR_BIT_IN1L] = evRise[`TSIR_EV_IN1L]; // R4
  end

  // Bus decode, an access is taken once in its first access cycle
  // Registered ready gives exactly one wait state, and the
  // access term drops while ready stands, so nothing is taken twice
  assign access = psel && penable && !pready;
  assign wrAccess = access && pwrite;
  assign rdAccess = access && !pwrite;
  // Register hits by byte address
  assign hitFreq = (paddr == `TSIR_ADDR_FREQ);
  assign hitStat = (paddr == `TSIR_ADDR_STAT);
  assign hitMask = (paddr == `TSIR_ADDR_MASK);
  assign hitCfg = (paddr == `TSIR_ADDR_CFG);
  // Anything else answers with an error
  assign mapped = hitFreq || hitStat || hitMask || hitCfg;

  // Software writes: clear vector, mask and select
  always @*
  begin
    clrVec = {`TSIR_REG_W{1'b0}};
    next_mask = mask;
    next_reportPathSelect = reportPathSelect;
    if (wrAccess && hitStat)
    begin
      // Ones clear, zeros keep, spare bit ignored
      clrVec = pwdata[`TSIR_REG_W-1:0] & STAT_USED; // R6
    end
    if (wrAccess && hitMask)
    begin
      // Spare bit of the mask cannot be set
      next_mask = pwdata[`TSIR_REG_W-1:0] & STAT_USED;
    end
    if (wrAccess && hitCfg)
    begin
      // Low reports the main loop, high the auxiliary loop
      next_reportPathSelect = pwdata[`TSIR_CFG_SEL]; // R1
    end
  end

  // Sticky flags, one per status bit
  generate
    for (g = 0; g < `TSIR_REG_W; g = g + 1)
    begin : gFlag
      // Set wins over a clear in the same cycle; spare bit stays zero
      assign next_status[g] = STAT_USED[g] && ((status[g] && !clrVec[g]) || setVec[g]); // R6
    end
  endgenerate

  // Frequency field of the loop chosen for the readout
  always @*
  begin
    if (reportPathSelect)
    begin
      // Auxiliary loop reported
      freqField = auxLoopFreq[`TSIR_FREQ_HI:`TSIR_FREQ_LO]; // R1
    end
    else
    begin
      // Main loop reported
      freqField = mainLoopFreq[`TSIR_FREQ_HI:`TSIR_FREQ_LO]; // R1
    end
  end

  // Read data and error flag for the answer cycle
  always @*
  begin
    next_prdata = {`TSIR_DATA_W{1'b0}};
    next_pslverr = 1'b0;
    if (access && !mapped)
    begin
      // Unmapped address, no data and no write effect
      next_pslverr = 1'b1;
    end
    else if (rdAccess)
    begin
      case (paddr)
        `TSIR_ADDR_FREQ:
        begin
          // Upper bits read zero
          next_prdata[`TSIR_FIELD_W-1:0] = freqField; // R1
        end
        `TSIR_ADDR_STAT:
        begin
          // Sticky flags as they stand before any clear
          next_prdata[`TSIR_REG_W-1:0] = status;
        end
        `TSIR_ADDR_MASK:
        begin
          // Mask as last written
          next_prdata[`TSIR_REG_W-1:0] = mask;
        end
        `TSIR_ADDR_CFG:
        begin
          // Select bit alone, the rest reads zero
          next_prdata[`TSIR_CFG_SEL] = reportPathSelect;
        end
        default:
        begin
          // Never reached, the decode above filters
          next_prdata = {`TSIR_DATA_W{1'b0}};
        end
      endcase
    end
  end

  // Ready answers one cycle after the access is taken
  always @*
  begin
    next_pready = access;
  end

  // Interrupt level from the flags and mask as they will stand
  always @*
  begin
    // Follows a mask write in the same edge
    next_irq = |(next_status & next_mask);
  end

  // Status, mask and select registers
  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      // Status comes up with two flags already set
      status <= `TSIR_STAT_RESET; // R2
      // All sources masked
      mask <= `TSIR_MASK_RESET;
      // Main loop reported
      reportPathSelect <= `TSIR_CFG_RESET;
    end
    else if (clockEn)
    begin
      // Clears land at the edge that takes the access
      status <= next_status;
      mask <= next_mask;
      reportPathSelect <= next_reportPathSelect; // R1
    end
  end

  // Bus answer, one cycle long
  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      // No answer and no data through reset
      prdata <= {`TSIR_DATA_W{1'b0}};
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else if (clockEn)
    begin
      // Data and error stand only with ready
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // Level interrupt, held low through reset
  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      irq <= 1'b0;
    end
    else if (clockEn)
    begin
      // High while an unmasked flag is set
      irq <= next_irq;
    end
  end
endmodule // tsir_top
`default_nettype wire

/* File: tsir_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module tsir_checker (
  // Clocking
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clockEn,
  // Bus
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  a_freq_hi_zero: assert property (pready && paddr == 12'h01C |-> !prdata[31:3])
    else $error("freq high bits set");
  a_stat_spare_zero: assert property (pready && paddr == 12'h020 |-> !(prdata & 32'hFFFFFF20))
    else $error("status spare bits set");
  a_irq_reset_low: assert property ($rose(rst_b) |-> !irq [*2])
    else $error("irq after reset");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready too long");
  a_ready_follows: assert property (clockEn && psel && penable && !pready |=> pready)
    else $error("ready late");
  a_idle_data_zero: assert property (!pready |-> !prdata)
    else $error("data outside answer");
  a_err_unmapped: assert property (pready && paddr > 12'h084 |-> pslverr)
    else $error("no error flag");
  // Main scenarios seen
  cover property (pready && pslverr);
  cover property ($rose(irq));
  cover property (pready && paddr == 12'h020);
endmodule // tsir_checker
bind tsir_top tsir_checker chk (.clock, .rst_b, .clockEn, .psel, .penable, .paddr, .prdata, .pready,
  .pslverr, .irq);
`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // Bus and event pin drive
  logic clock = 0, rst_b = 0, clockEn = 1, psel = 0, penable = 0, pwrite = 0, rerr;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, rdata;
  logic [6:0] ev = 0;
  wire [31:0] prdata;
  wire pready, pslverr, irq;
  int failures = 0, testsRun = 0, i;
  // 50 MHz clock
  always #10 clock = ~clock;
  tsir_top dut (.clock, .rst_b, .clockEn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .mainLoopFreq(19'h5ABCD), .auxLoopFreq(19'h21234),
    .frameSyncInAlarm(ev[6]), .auxLoopLocked(ev[5]), .auxLoopNoInputs(ev[4]),
    .inTwoCodeViolation(ev[3]), .inTwoSignalLoss(ev[2]), .inOneCodeViolation(ev[1]),
    .inOneSignalLoss(ev[0]), .irq);
  // Verdict and end
  task finish_test;
    if (failures == 0 && testsRun > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Value compare
  task chk(input string n, input logic [31:0] e, g);
    testsRun++;
    if (g !== e)
    begin
      $display("wrong value %s exp %h got %h", n, e, g);
      failures++;
    end
  endtask
  // One APB transfer, held until ready
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1;
    n = 0;
    do @(posedge clock); while (pready !== 1 && ++n < 9);
    chk("ready", 1, pready);
    rdata = prdata;
    rerr = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // Read and compare
  task rd(input logic [11:0] a, input logic [31:0] e);
    xfer(0, a, 0);
    chk("read", e, rdata);
  endtask
  // Main sequence
  initial
  begin
    repeat (3) @(posedge clock);
    rst_b <= 1;
    rd(12'h020, 32'h50);
    rd(12'h01C, 32'h5);
    xfer(1, 12'h084, 1);
    rd(12'h084, 32'h1);
    rd(12'h01C, 32'h2);
    xfer(1, 12'h020, 0);
    rd(12'h020, 32'h50);
    xfer(1, 12'h020, 32'h50);
    rd(12'h020, 0);
    // Each event pulsed, seen sticky, then cleared; mask still zero
    for (i = 0; i < 7; i++)
    begin
      ev <= 7'h1 << i;
      repeat (5) @(posedge clock);
      ev <= 0;
      repeat (5) @(posedge clock);
      rd(12'h020, 32'h1 << (i + (i > 4)));
      chk("irq", 0, irq);
      xfer(1, 12'h020, 32'hFF);
      rd(12'h020, 0);
    end
    // Unmasked event drives the interrupt
    xfer(1, 12'h080, 1);
    rd(12'h080, 32'h1);
    ev <= 1;
    repeat (5) @(posedge clock);
    ev <= 0;
    chk("irq", 1, irq);
    xfer(1, 12'h020, 32'h1);
    chk("irq", 0, irq);
    // Frozen enable: an event pulse is not seen
    clockEn <= 0;
    ev <= 1;
    repeat (5) @(posedge clock);
    ev <= 0;
    repeat (5) @(posedge clock);
    clockEn <= 1;
    rd(12'h020, 0);
    chk("irq", 0, irq);
    xfer(1, 12'h3FC, 0);
    chk("err", 1, rerr);
    finish_test;
  end
  // Hang guard
  initial
  begin
    #100us;
    failures++;
    finish_test;
  end
endmodule // tb_top
`default_nettype wire
